// ---- rtl/sscp_pkg.sv ----
// Shared constants of the servo special-bits and communication parameter bank.
// Assumes a word-wide parameter write port driven by the panel or serial front end.
package sscp_pkg;
   localparam int            PW                = 16;
   localparam logic [15:0]   ADDR_SPECIAL_TWO  = 16'h0284;
   localparam logic [15:0]   ADDR_INERTIA_THR  = 16'h0286;
   localparam logic [15:0]   ADDR_STATION      = 16'h0300;
   localparam logic [15:0]   ADDR_LINE_RATE    = 16'h0302;
   localparam logic [15:0]   RST_SPECIAL_TWO   = 16'h0000;
   localparam logic [15:0]   RST_INERTIA_THR   = 16'h000f;
   localparam logic [15:0]   RST_STATION       = 16'h007f;
   localparam logic [15:0]   RST_LINE_RATE     = 16'h0033;
   localparam logic [15:0]   INERTIA_THR_MAX   = 16'h00c8;
   localparam logic [15:0]   STATION_MIN       = 16'h0001;
   localparam logic [15:0]   STATION_MAX       = 16'h007f;
   localparam logic [3:0]    RATE_DIGIT_MAX    = 4'h5;
   localparam logic [7:0]    STATION_WILDCARD  = 8'hff;
   localparam logic [7:0]    SPD_LIMIT_ALWAYS  = 8'h10;
   localparam int            BIT_LV_AUTOCLR    = 2;
   localparam int            BIT_TEMP_HIDE     = 7;
   localparam int            BIT_WARN_ROUTE    = 9;
   localparam int            BIT_PULSE_DIRECT  = 15;
   localparam int            BIT_ENC_ERR_OFF   = 13;
   localparam logic [7:0]    DO_FUNC_WARN      = 8'h11;
   localparam logic [7:0]    DO_FUNC_ALT       = 8'h07;
   localparam int            SETTLE_CYCLES     = 1250;
endpackage

// ---- rtl/sscp_bank.sv ----
// Parameter bank: special bits two, inertia threshold, station address, line rate.
// Assumes wr/rd strobes and addr come from logic on clk_sys_i; drive-side
// events and digital inputs are asynchronous and are synchronised here.
// How it works
// - Bit13 of special bits one gates encoder-output detection
// - Torque passed, inverted, or zero by inputs
// - Config 0x10 keeps speed limit always on
// - Bit2 chooses latched or self-clearing low-voltage error
// - Bit7 hides the motor temperature warning
// - Bit9 routes alarm to output function 0x11/0x07
// - Bit15 selects quadrupled or direct pulse count
// - Estimate below threshold long enough means done
// - Wildcard 0xFF frames accepted; register refuses 0xFF
// - Line rate digits per port, default 0x0033
`timescale 1ns/100ps
module sscp_bank
   import sscp_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   input  wire logic                clk_sys_i,
   input  wire logic                nrst_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   input  wire logic [15:0]         addr_i,
   input  wire logic [PW-1:0]       wdata_i,
   input  wire logic                enc_out_err_off_i,
   input  wire logic                enc_out_fault_i,
   input  wire logic                torque_pass_input_i,
   input  wire logic                torque_invert_input_i,
   input  wire logic signed [15:0]  torque_cmd_i,
   input  wire logic [7:0]          speed_torque_limit_config_i,
   input  wire logic                speed_limit_switch_input_i,
   input  wire logic                low_voltage_i,
   input  wire logic                low_voltage_clear_i,
   input  wire logic                motor_temp_warn_i,
   input  wire logic                listed_alarm_event_i,
   input  wire logic [15:0]         encoder_output_pulse_count_i,
   input  wire logic                tune_active_i,
   input  wire logic [15:0]         inertia_estimate_i,
   input  wire logic [7:0]          frame_addr_i,
   output logic [PW-1:0]            rdata_o,
   output logic                     wr_reject_o,
   output logic                     encoder_output_alarm_o,
   output logic signed [15:0]       torque_out_o,
   output logic                     speed_limit_on_o,
   output logic                     low_voltage_err_o,
   output logic                     temp_warn_show_o,
   output logic                     warn_do_active_o,
   output logic [7:0]               warn_do_func_o,
   output logic [17:0]              enc_edges_per_rev_o,
   output logic                     inertia_done_o,
   output logic                     frame_match_o,
   output logic [PW-1:0]            station_address_o,
   output logic [PW-1:0]            line_rate_select_o
);
   // Overview of the block
   // The bank keeps four 16-bit parameters behind a word-wide write and read port.
   // Writes take effect at the edge that samples wr_i; a refused write leaves the
   // stored word untouched and pulses wr_reject_o for one cycle.
   // Reads answer at the edge that samples rd_i, and the read word
   // holds until the next read, so a slow front end can pick it up late.
   // The drive-side functions are small pieces of combinational logic fed by
   // synchronised pins, same-clock inputs and the stored parameter bits, all registered once.
   // Latency figures seen by a user
   // Same-clock inputs reach the outputs one cycle later.
   // Pin inputs take three cycles: two synchroniser flops and the output flop.
   // A pin pulse shorter than one clock period may be missed entirely;
   // the drive side holds its levels far longer than that.
   // Limitations
   // Only the parameters of this stretch are decoded; other addresses refuse
   // writes and read back as zero.
   // special_bits_two accepts any word, reserved bits included, so software
   // reading it back sees exactly what it wrote.
   // The station address check refuses the wildcard by range alone, because
   // 0xFF lies above the highest legal address.
   // Distinct addresses across drives are the host's duty; nothing here can
   // detect a duplicate on the shared line.
   // Asynchronous single-bit inputs, two flops each
   localparam int NS = 9;
   logic [NS-1:0] sy_a_q;
   logic [NS-1:0] sy_b_q;
   logic [NS-1:0] sy_in;
   assign sy_in = {enc_out_err_off_i, enc_out_fault_i, torque_pass_input_i,
                   torque_invert_input_i, speed_limit_switch_input_i, low_voltage_i,
                   low_voltage_clear_i, motor_temp_warn_i, listed_alarm_event_i};
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sy_a_q <= '0;
         sy_b_q <= '0;
      end else begin
         sy_a_q <= sy_in;
         sy_b_q <= sy_a_q;
      end
   end
   // Synchronised copies, named after the pin they follow
   logic          s_enc_off;
   logic          s_enc_fault;
   logic          s_tqp;
   logic          s_tqn;
   logic          s_spd_sw;
   logic          s_lv;
   logic          s_lv_clr;
   logic          s_temp;
   logic          s_alarm;
   // Reset to zero matches the idle level of every pin, so no false event
   // appears right after reset.
   assign {s_enc_off, s_enc_fault, s_tqp, s_tqn, s_spd_sw, s_lv, s_lv_clr,
           s_temp, s_alarm} = sy_b_q;

   // Register file
   // Each stored word has its next value computed below and only registered
   // in the clocked process, so a refused write simply keeps the old word.
   logic [PW-1:0] sp2_q;
   logic [PW-1:0] sp2_d;
   logic [PW-1:0] thr_q;
   logic [PW-1:0] thr_d;
   logic [PW-1:0] sta_q;
   logic [PW-1:0] sta_d;
   logic [PW-1:0] rate_q;
   logic [PW-1:0] rate_d;
   logic [PW-1:0] rdata_d;
   logic          rej_d;
   logic          rej_q;
   // A write and a read in the same cycle are both served; the read returns
   // the word as it stood before the write lands.
   always_comb begin
      sp2_d   = sp2_q;
      thr_d   = thr_q;
      sta_d   = sta_q;
      rate_d  = rate_q;
      rej_d   = 1'b0;
      rdata_d = rdata_o;
      if (wr_i) begin
         unique case (addr_i)
            ADDR_SPECIAL_TWO: sp2_d = wdata_i;
            ADDR_INERTIA_THR: begin
               if (wdata_i <= INERTIA_THR_MAX) thr_d = wdata_i;
               else rej_d = 1'b1;
            end
            ADDR_STATION: begin
               if (wdata_i >= STATION_MIN && wdata_i <= STATION_MAX) sta_d = wdata_i;
               else rej_d = 1'b1;
            end
            ADDR_LINE_RATE: begin
               if (wdata_i[15:8] == 8'h00 && wdata_i[7:4] <= RATE_DIGIT_MAX
                   && wdata_i[3:0] <= RATE_DIGIT_MAX) rate_d = wdata_i;
               else rej_d = 1'b1;
            end
            default: rej_d = 1'b1;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            ADDR_SPECIAL_TWO: rdata_d = sp2_q;
            ADDR_INERTIA_THR: rdata_d = thr_q;
            ADDR_STATION:     rdata_d = sta_q;
            ADDR_LINE_RATE:   rdata_d = rate_q;
            default:          rdata_d = '0;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sp2_q   <= RST_SPECIAL_TWO;
         thr_q   <= RST_INERTIA_THR;
         sta_q   <= RST_STATION;
         rate_q  <= RST_LINE_RATE;
         rej_q   <= 1'b0;
         rdata_o <= '0;
      end else begin
         sp2_q   <= sp2_d;
         thr_q   <= thr_d;
         sta_q   <= sta_d;
         rate_q  <= rate_d;
         rej_q   <= rej_d;
         rdata_o <= rdata_d;
      end
   end

   // Drive functions
   // Next values of the drive-side outputs
   logic               enc_d;
   logic               spd_d;
   logic               lv_d;
   logic               temp_d;
   logic               wact_d;
   logic               done_d;
   logic               match_d;
   logic               lv_q;
   // Torque negation wraps the most negative command onto itself; the
   // command range in use never reaches it.
   // The edge count is two bits wider than the pulse count so that the
   // quadrupled figure never overflows.
   // The settle counter saturates at SETTLE and holds there while the
   // estimate stays low, so done stays high without the count wrapping.
   logic signed [15:0] tq_d;
   logic [7:0]         wfunc_d;
   logic [17:0]        edges_d;
   logic [$clog2(SETTLE+1)-1:0] cnt_q, cnt_d;
   always_comb begin
      enc_d = s_enc_fault & ~s_enc_off;
      unique case ({s_tqp, s_tqn})
         2'b10:   tq_d = torque_cmd_i;
         2'b01:   tq_d = 16'(-torque_cmd_i);
         default: tq_d = 16'sh0000;
      endcase
      spd_d = (speed_torque_limit_config_i == SPD_LIMIT_ALWAYS) | s_spd_sw;
      // set wins over clear; auto-clear when bit2 set
      if (s_lv) lv_d = 1'b1;
      else if (sp2_q[BIT_LV_AUTOCLR] || s_lv_clr) lv_d = 1'b0;
      else lv_d = lv_q;
      temp_d = s_temp & ~sp2_q[BIT_TEMP_HIDE];
      wact_d  = s_alarm;
      wfunc_d = sp2_q[BIT_WARN_ROUTE] ? DO_FUNC_ALT : DO_FUNC_WARN;
      edges_d = sp2_q[BIT_PULSE_DIRECT] ? {2'b00, encoder_output_pulse_count_i}
                                        : {encoder_output_pulse_count_i, 2'b00};
      cnt_d  = cnt_q;
      done_d = inertia_done_o;
      if (!tune_active_i || inertia_estimate_i >= thr_q) begin
         cnt_d  = '0;
         done_d = 1'b0;
      end else if (cnt_q == ($clog2(SETTLE+1))'(SETTLE)) begin
         done_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
      // Frame match compares only the low byte: legal addresses fit in it,
      // and the wildcard is checked first so it always answers.
      // wildcard frame address
      match_d = (frame_addr_i == STATION_WILDCARD) || (frame_addr_i == sta_q[7:0]);
   end
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         encoder_output_alarm_o <= 1'b0;
         torque_out_o           <= '0;
         speed_limit_on_o       <= 1'b0;
         lv_q                   <= 1'b0;
         temp_warn_show_o       <= 1'b0;
         warn_do_active_o       <= 1'b0;
         warn_do_func_o         <= DO_FUNC_WARN;
         enc_edges_per_rev_o    <= '0;
         cnt_q                  <= '0;
         inertia_done_o         <= 1'b0;
         frame_match_o          <= 1'b0;
      end else begin
         encoder_output_alarm_o <= enc_d;
         torque_out_o           <= tq_d;
         speed_limit_on_o       <= spd_d;
         lv_q                   <= lv_d;
         temp_warn_show_o       <= temp_d;
         warn_do_active_o       <= wact_d;
         warn_do_func_o         <= wfunc_d;
         enc_edges_per_rev_o    <= edges_d;
         cnt_q                  <= cnt_d;
         inertia_done_o         <= done_d;
         frame_match_o          <= match_d;
      end
   end
   // These outputs are plain copies of flops, kept as wires to avoid a
   // second register holding the same value.
   assign low_voltage_err_o  = lv_q;
   assign wr_reject_o        = rej_q;
   assign station_address_o  = sta_q;
   assign line_rate_select_o = rate_q;
endmodule

// ---- tb/sscp_bank_properties.sv ----
// Port checker of the parameter bank.
// Assumes one clock domain; bound onto every sscp_bank instance.
`timescale 1ns/100ps
module sscp_bank_properties
   import sscp_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         nrst_i,
   input wire logic         wr_i,
   input wire logic         rd_i,
   input wire logic [15:0]  addr_i,
   input wire logic [PW-1:0] wdata_i,
   input wire logic         torque_pass_input_i,
   input wire logic         torque_invert_input_i,
   input wire logic [7:0]   speed_torque_limit_config_i,
   input wire logic [7:0]   frame_addr_i,
   input wire logic [PW-1:0] rdata_o,
   input wire logic         wr_reject_o,
   input wire logic signed [15:0] torque_out_o,
   input wire logic         speed_limit_on_o,
   input wire logic         frame_match_o,
   input wire logic [PW-1:0] station_address_o,
   input wire logic [PW-1:0] line_rate_select_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   property p_sta_wr;
      wr_i && addr_i == ADDR_STATION && wdata_i inside {[STATION_MIN:STATION_MAX]}
         |=> station_address_o == $past(wdata_i) && !wr_reject_o;
   endproperty
   a_sta_wr: assert property (p_sta_wr) else $error("station write lost");
   property p_wild;
      wr_i && addr_i == ADDR_STATION && wdata_i == {8'h00, STATION_WILDCARD}
         |=> wr_reject_o && $stable(station_address_o);
   endproperty
   a_wild: assert property (p_wild) else $error("wildcard stored");
   property p_sta_rng;
      station_address_o inside {[STATION_MIN:STATION_MAX]};
   endproperty
   a_sta_rng: assert property (p_sta_rng) else $error("station out of range");
   property p_rate;
      line_rate_select_o[15:8] == 8'h00 && line_rate_select_o[7:4] <= RATE_DIGIT_MAX
         && line_rate_select_o[3:0] <= RATE_DIGIT_MAX;
   endproperty
   a_rate: assert property (p_rate) else $error("line rate out of range");
   property p_rd;
      rd_i && !wr_i && addr_i == ADDR_STATION |=> rdata_o == $past(station_address_o);
   endproperty
   a_rd: assert property (p_rd) else $error("station read wrong");
   property p_tq0;
      (torque_pass_input_i == torque_invert_input_i) [*4] |-> torque_out_o == 16'sh0000;
   endproperty
   a_tq0: assert property (p_tq0) else $error("torque not zero");
   property p_spd;
      speed_torque_limit_config_i == SPD_LIMIT_ALWAYS |=> speed_limit_on_o;
   endproperty
   a_spd: assert property (p_spd) else $error("speed limit off");
   property p_frm;
      frame_addr_i == STATION_WILDCARD |=> frame_match_o;
   endproperty
   a_frm: assert property (p_frm) else $error("wildcard frame missed");
endmodule
bind sscp_bank sscp_bank_properties u_prop (.*);

// ---- tb/sscp_host.sv ----
// Host controller model: parameter port cycles and received frame addresses.
// Assumes the bank samples on the rising edge of clk_sys_i.
`timescale 1ns/100ps
module sscp_host (
   input  wire logic   clk_sys_i,
   output logic        wr_o,
   output logic        rd_o,
   output logic [15:0] addr_o,
   output logic [15:0] wdata_o,
   output logic [7:0]  frame_o
);
   initial {wr_o, rd_o, addr_o, wdata_o, frame_o} = '0;
   // Released bus shows inverted values so stale data cannot pass
   task automatic acc(input logic w, input logic [15:0] a, d);
      @(posedge clk_sys_i);
      {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
      @(posedge clk_sys_i);
      {wr_o, rd_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
   endtask
   task automatic frm(input logic [7:0] a);
      @(posedge clk_sys_i);
      frame_o <= a;
   endtask
endmodule

// ---- tb/sscp_bank_tb_top.sv ----
// Testbench of the parameter bank: register port and drive functions.
// Assumes sscp_host drives the register port and frame address.
`timescale 1ns/100ps
module sscp_bank_tb_top
   import sscp_pkg::*;
;
   logic clk_sys_i = 0, nrst_i = 0, wr_i, rd_i, wr_reject_o, frame_match_o;
   logic [15:0] addr_i, wdata_i, encoder_output_pulse_count_i, inertia_estimate_i, rdata_o;
   logic enc_out_err_off_i, enc_out_fault_i, torque_pass_input_i, torque_invert_input_i;
   logic speed_limit_switch_input_i, low_voltage_i, low_voltage_clear_i, motor_temp_warn_i;
   logic listed_alarm_event_i, tune_active_i, encoder_output_alarm_o, speed_limit_on_o;
   logic low_voltage_err_o, temp_warn_show_o, warn_do_active_o, inertia_done_o;
   logic signed [15:0] torque_cmd_i, torque_out_o;
   logic [7:0] speed_torque_limit_config_i, frame_addr_i, warn_do_func_o;
   logic [15:0] station_address_o, line_rate_select_o;
   logic [17:0] enc_edges_per_rev_o;
   int n_fail = 0, checks = 0;
   sscp_bank #(.SETTLE(4)) dut (.*);
   sscp_host host (.clk_sys_i(clk_sys_i), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
      .wdata_o(wdata_i), .frame_o(frame_addr_i));
   always #4 clk_sys_i = ~clk_sys_i;
   task automatic chk(input string n, input logic [17:0] e, g);
      checks++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         n_fail++;
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, d, input logic r);
      host.acc(1'b1, a, d);
      #1 chk("wr_reject_o", r, wr_reject_o);
   endtask
   task automatic rd(input logic [15:0] a, e);
      host.acc(1'b0, a, 16'h0000);
      #1 chk("rdata_o", e, rdata_o);
   endtask
   task automatic t_regs;
      rd(ADDR_SPECIAL_TWO, RST_SPECIAL_TWO);
      rd(ADDR_INERTIA_THR, RST_INERTIA_THR);
      rd(ADDR_STATION, RST_STATION);
      rd(ADDR_LINE_RATE, RST_LINE_RATE);
      wr(ADDR_STATION, 16'h00ff, 1);
      wr(ADDR_STATION, 16'h0000, 1);
      wr(ADDR_STATION, 16'h0080, 1);
      wr(ADDR_STATION, 16'h0001, 0);
      rd(ADDR_STATION, 16'h0001);
      chk("station_address_o", 16'h0001, station_address_o);
      wr(ADDR_LINE_RATE, 16'h0056, 1);
      wr(ADDR_LINE_RATE, 16'h0155, 1);
      wr(ADDR_LINE_RATE, 16'h0055, 0);
      rd(ADDR_LINE_RATE, 16'h0055);
      chk("line_rate_select_o", 16'h0055, line_rate_select_o);
      wr(ADDR_INERTIA_THR, 16'h00c9, 1);
      wr(ADDR_INERTIA_THR, 16'h00c8, 0);
      rd(ADDR_INERTIA_THR, 16'h00c8);
      wr(16'h0288, 16'h0001, 1);
      rd(16'h0288, 16'h0000);
   endtask
   task automatic t_torque;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_i);
         {torque_pass_input_i, torque_invert_input_i} <= 2'(k);
         w(5);
         chk("torque_out_o", k == 2 ? torque_cmd_i : k == 1 ? -torque_cmd_i : 16'sh0,
            torque_out_o);
      end
   endtask
   task automatic t_misc;
      chk("speed_limit_on_o", 0, speed_limit_on_o);
      @(posedge clk_sys_i);
      speed_limit_switch_input_i <= 1;
      w(5);
      chk("speed_limit_on_o", 1, speed_limit_on_o);
      @(posedge clk_sys_i);
      speed_limit_switch_input_i <= 0;
      w(5);
      chk("speed_limit_on_o", 0, speed_limit_on_o);
      @(posedge clk_sys_i);
      speed_torque_limit_config_i <= SPD_LIMIT_ALWAYS;
      host.frm(8'h05);
      w(2);
      chk("speed_limit_on_o", 1, speed_limit_on_o);
      chk("frame_match_o", 0, frame_match_o);
      host.frm(STATION_WILDCARD);
      w(2);
      chk("frame_match_o", 1, frame_match_o);
   endtask
   task automatic t_bits(input logic [15:0] b);
      wr(ADDR_SPECIAL_TWO, b, 0);
      @(posedge clk_sys_i);
      {low_voltage_i, motor_temp_warn_i, listed_alarm_event_i} <= 3'b111;
      w(5);
      @(posedge clk_sys_i);
      low_voltage_i <= 0;
      w(5);
      chk("low_voltage_err_o", !b[BIT_LV_AUTOCLR], low_voltage_err_o);
      chk("temp_warn_show_o", !b[BIT_TEMP_HIDE], temp_warn_show_o);
      chk("warn_do_active_o", 1, warn_do_active_o);
      chk("warn_do_func_o", b[BIT_WARN_ROUTE] ? DO_FUNC_ALT : DO_FUNC_WARN,
         warn_do_func_o);
      chk("enc_edges", b[BIT_PULSE_DIRECT] ? 18'h009c4 : 18'h02710,
         enc_edges_per_rev_o);
      @(posedge clk_sys_i);
      {low_voltage_clear_i, listed_alarm_event_i} <= 2'b10;
      w(5);
      chk("low_voltage_err_o", 0, low_voltage_err_o);
      @(posedge clk_sys_i);
      low_voltage_clear_i <= 0;
   endtask
   task automatic t_alarm;
      @(posedge clk_sys_i);
      enc_out_fault_i <= 1;
      w(5);
      chk("encoder_output_alarm_o", 1, encoder_output_alarm_o);
      @(posedge clk_sys_i);
      enc_out_err_off_i <= 1;
      w(5);
      chk("encoder_output_alarm_o", 0, encoder_output_alarm_o);
   endtask
   task automatic t_tune;
      @(posedge clk_sys_i);
      {tune_active_i, inertia_estimate_i} <= {1'b1, 16'h00c7};
      w(3);
      chk("inertia_done_o", 0, inertia_done_o);
      w(6);
      chk("inertia_done_o", 1, inertia_done_o);
      @(posedge clk_sys_i);
      inertia_estimate_i <= 16'h00c8;
      w(3);
      chk("inertia_done_o", 0, inertia_done_o);
   endtask
   task automatic end_of_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {enc_out_err_off_i, enc_out_fault_i, torque_pass_input_i, torque_invert_input_i} = '0;
      {speed_limit_switch_input_i, low_voltage_i, low_voltage_clear_i} = '0;
      {motor_temp_warn_i, listed_alarm_event_i, tune_active_i} = '0;
      {torque_cmd_i, encoder_output_pulse_count_i} = {16'sh0100, 16'h09c4};
      {inertia_estimate_i, speed_torque_limit_config_i} = {16'h00c8, 8'h00};
      repeat (6) @(posedge clk_sys_i);
      nrst_i <= 1;
      t_regs;
      t_torque;
      t_misc;
      t_bits(16'h0000);
      t_bits(16'h8284);
      t_alarm;
      t_tune;
      end_of_test;
   end
   initial begin
      #100000;
      n_fail++;
      end_of_test;
   end
endmodule
